// >>> rtl/ftp_monitor.sv
// Fan tach period monitor: period count, byte-freeze read, speed limits, target.
// Assumes an 8-bit register port (address, write strobe, read strobe) on i_clk_sys.
`timescale 1ns/10ps
`default_nettype none
module ftp_monitor
#(
   parameter int PULSES = 2             // Tach pulses per revolution
)
(
   input  wire logic       i_clk_sys,    // System clock, 40 MHz
   input  wire logic       i_rst_n,      // Sync reset, active low
   input  wire logic       i_tach,       // Fan tach pin, asynchronous
   input  wire logic       i_regulate,   // Speed regulation mode selected
   input  wire logic [7:0] i_addr,       // Register byte address
   input  wire logic       i_wr,         // Write strobe, one cycle
   input  wire logic [7:0] i_wdata,      // Write data
   input  wire logic       i_rd,         // Read strobe, one cycle
   output logic      [7:0] o_rdata,      // Read data, valid cycle after i_rd
   output logic            o_too_slow,   // Period above slow limit
   output logic            o_too_fast,   // Period below fast limit
   output logic            o_in_band,    // Regulation error within deadband
   output logic            o_adjust_up,  // Regulation: speed up fan
   output logic            o_adjust_dn,  // Regulation: slow fan down
   output logic            o_new_period  // One-cycle pulse on each new measurement
);
   logic        tach_rise;
   logic [15:0] count;
   logic [15:0] period;
   logic [7:0]  held_high;
   logic        frozen;
   logic        started;
   logic [1:0]  pulse_cnt;
   logic [15:0] slow_limit;
   logic [15:0] fast_limit;
   logic [15:0] target;
   logic [15:0] next_count;
   logic [15:0] next_period;
   logic [7:0]  next_held_high;
   logic        next_frozen;
   logic        next_started;
   logic [1:0]  next_pulse_cnt;
   logic [15:0] next_slow_limit;
   logic [15:0] next_fast_limit;
   logic [15:0] next_target;
   logic [7:0]  next_rdata;
   logic        next_too_slow;
   logic        next_too_fast;
   logic        next_in_band;
   logic        next_up;
   logic        next_dn;
   logic        rev_done;
   logic [15:0] diff;

   localparam logic [15:0] CNT_ALL = ftp_pkg::CNT_MAX;

   ftp_edge_sync u_sync
   (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (i_rst_n),
      .i_pin     (i_tach),
      .o_rise    (tach_rise)
   );

   // Revolution counter and measured period
   always_comb
   begin
      rev_done       = 1'b0;
      next_pulse_cnt = pulse_cnt;
      next_started   = started;
      next_period    = period;
      next_count     = (count == ftp_pkg::CNT_MAX) ? count : count + ftp_pkg::CNT_ONE;
      if (tach_rise)
      begin
         if (!started)
         begin
            next_started   = 1'b1;
            next_count     = '0;
            next_pulse_cnt = '0;
         end
         else if (pulse_cnt == 2'(PULSES - 1))
         begin
            rev_done       = 1'b1;
            next_period    = count;
            next_count     = '0;
            next_pulse_cnt = '0;
         end
         else
         begin
            next_pulse_cnt = pulse_cnt + 2'h1;
         end
      end
   end

   // Register port: writes, reads and high-byte freeze
   always_comb
   begin
      next_slow_limit = slow_limit;
      next_fast_limit = fast_limit;
      next_target     = target;
      next_frozen     = frozen;
      next_held_high  = frozen ? held_high : period[15:8];
      next_rdata      = o_rdata;
      if (i_wr)
      begin
         unique case (i_addr)
            ftp_pkg::ADDR_SLOW_LOW:    next_slow_limit[7:0]  = i_wdata;
            ftp_pkg::ADDR_SLOW_HIGH:   next_slow_limit[15:8] = i_wdata;
            ftp_pkg::ADDR_FAST_LOW:    next_fast_limit[7:0]  = i_wdata;
            ftp_pkg::ADDR_FAST_HIGH:   next_fast_limit[15:8] = i_wdata;
            ftp_pkg::ADDR_TARGET_LOW:  next_target[7:0]      = i_wdata;
            ftp_pkg::ADDR_TARGET_HIGH: next_target[15:8]     = i_wdata;
            default:                   next_target           = target;
         endcase
      end
      if (i_rd)
      begin
         unique case (i_addr)
            ftp_pkg::ADDR_PERIOD_LOW:
            begin
               next_rdata     = period[7:0];
               next_frozen    = 1'b1;
               // Fresh copy on every low read, so both halves match
               next_held_high = period[15:8];
            end
            ftp_pkg::ADDR_PERIOD_HIGH:
            begin
               next_rdata  = frozen ? held_high : period[15:8];
               next_frozen = 1'b0;
            end
            ftp_pkg::ADDR_SLOW_LOW:    next_rdata = slow_limit[7:0];
            ftp_pkg::ADDR_SLOW_HIGH:   next_rdata = slow_limit[15:8];
            ftp_pkg::ADDR_FAST_LOW:    next_rdata = fast_limit[7:0];
            ftp_pkg::ADDR_FAST_HIGH:   next_rdata = fast_limit[15:8];
            ftp_pkg::ADDR_TARGET_LOW:  next_rdata = target[7:0];
            ftp_pkg::ADDR_TARGET_HIGH: next_rdata = target[15:8];
            default:                   next_rdata = ftp_pkg::RST_ZERO;
         endcase
      end
   end

   // Limit checks and regulation error, judged on the live period
   always_comb
   begin
      next_too_slow = period > slow_limit;
      next_too_fast = period < fast_limit;
      diff          = (period > target) ? period - target : target - period;
      next_in_band  = diff <= ftp_pkg::REG_DEADBAND;
      // Longer period than target means fan too slow
      next_up       = i_regulate & ~next_in_band & (period > target);
      next_dn       = i_regulate & ~next_in_band & (period < target);
   end

   // Register all state
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         count        <= '0;
         period       <= {ftp_pkg::RST_ZERO, ftp_pkg::RST_ZERO};
         held_high    <= ftp_pkg::RST_ZERO;
         frozen       <= 1'b0;
         started      <= 1'b0;
         pulse_cnt    <= '0;
         slow_limit   <= {ftp_pkg::RST_ONES, ftp_pkg::RST_ONES};
         fast_limit   <= {ftp_pkg::RST_ZERO, ftp_pkg::RST_ZERO};
         target       <= {ftp_pkg::RST_ONES, ftp_pkg::RST_ONES};
         o_rdata      <= ftp_pkg::RST_ZERO;
         o_too_slow   <= 1'b0;
         o_too_fast   <= 1'b0;
         o_in_band    <= 1'b0;
         o_adjust_up  <= 1'b0;
         o_adjust_dn  <= 1'b0;
         o_new_period <= 1'b0;
      end
      else
      begin
         count        <= next_count;
         period       <= next_period;
         held_high    <= next_held_high;
         frozen       <= next_frozen;
         started      <= next_started;
         pulse_cnt    <= next_pulse_cnt;
         slow_limit   <= next_slow_limit;
         fast_limit   <= next_fast_limit;
         target       <= next_target;
         o_rdata      <= next_rdata;
         o_too_slow   <= next_too_slow;
         o_too_fast   <= next_too_fast;
         o_in_band    <= next_in_band;
         o_adjust_up  <= next_up;
         o_adjust_dn  <= next_dn;
         o_new_period <= rev_done;
      end
   end

   // Period byte pair read: high byte read returns the frozen copy
   sequence s_low_read;
      i_rd && i_addr == ftp_pkg::ADDR_PERIOD_LOW;
   endsequence
   sequence s_high_read;
      i_rd && i_addr == ftp_pkg::ADDR_PERIOD_HIGH;
   endsequence
   sequence s_read_gap;
      !i_rd;
   endsequence

   a_freeze_high_byte: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      s_low_read ##1 s_read_gap ##1 s_high_read
      |=> o_rdata == $past(period[15:8], 3))
      else $error("high byte not from frozen copy");

   a_low_byte_read: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      s_low_read |=> o_rdata == $past(period[7:0]))
      else $error("low byte read wrong");

   a_period_held: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      !rev_done |=> $stable(period))
      else $error("period changed without revolution");

   a_period_capture: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      rev_done |=> period == $past(count) && o_new_period)
      else $error("period capture wrong");

   a_slow_flag: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      ##1 o_too_slow == ($past(period) > $past(slow_limit)))
      else $error("slow flag wrong");

   a_fast_flag: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      ##1 o_too_fast == ($past(period) < $past(fast_limit)))
      else $error("fast flag wrong");

   a_deadband_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      o_in_band |-> !o_adjust_up && !o_adjust_dn)
      else $error("adjust inside deadband");

   a_target_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      i_wr && i_addr == ftp_pkg::ADDR_TARGET_HIGH |=> target[15:8] == $past(i_wdata))
      else $error("target write lost");

   a_reset_values: assert property (@(posedge i_clk_sys)
      !i_rst_n |=> target == CNT_ALL && slow_limit == CNT_ALL && fast_limit == '0)
      else $error("reset values wrong");
endmodule
`default_nettype wire

// >>> rtl/ftp_pkg.sv
// Package for the fan tach period monitor: register offsets, reset values, limits.
// Assumes an 8-bit register port with a byte address, inside one clock domain.
package ftp_pkg;
   localparam logic [7:0]  ADDR_PERIOD_LOW   = 8'h08;
   localparam logic [7:0]  ADDR_PERIOD_HIGH  = 8'h09;
   localparam logic [7:0]  ADDR_SLOW_LOW     = 8'h10;
   localparam logic [7:0]  ADDR_SLOW_HIGH    = 8'h11;
   localparam logic [7:0]  ADDR_FAST_LOW     = 8'h12;
   localparam logic [7:0]  ADDR_FAST_HIGH    = 8'h13;
   localparam logic [7:0]  ADDR_TARGET_LOW   = 8'h1e;
   localparam logic [7:0]  ADDR_TARGET_HIGH  = 8'h1f;
   localparam logic [7:0]  RST_ONES          = 8'hff;
   localparam logic [7:0]  RST_ZERO          = 8'h00;
   localparam logic [15:0] REG_DEADBAND      = 16'h000a;
   localparam logic [15:0] CNT_ONE           = 16'h0001;
   localparam logic [15:0] CNT_MAX           = 16'hffff;
   localparam logic [1:0]  PULSES_PER_REV    = 2'h2;
endpackage

// >>> rtl/ftp_edge_sync.sv
// Two-flop synchroniser with rising-edge pulse for the tach pin.
// Assumes the pin is asynchronous to i_clk_sys.
`timescale 1ns/10ps
`default_nettype none
module ftp_edge_sync
(
   input  wire logic i_clk_sys,   // System clock
   input  wire logic i_rst_n,     // Sync reset, active low
   input  wire logic i_pin,       // Asynchronous pin
   output logic      o_rise       // One-cycle pulse on a rising edge
);
   logic meta;
   logic sync;
   logic sync_d;
   logic next_meta;
   logic next_sync;
   logic next_sync_d;
   logic next_rise;

   // Next values: first flop only feeds the second
   always_comb
   begin
      next_meta   = i_pin;
      next_sync   = meta;
      next_sync_d = sync;
      next_rise   = sync & ~sync_d;
   end

   // Register stage
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         // Idle level of the pulled-up pin, so no false edge after reset
         meta   <= 1'b1;
         sync   <= 1'b1;
         sync_d <= 1'b1;
         o_rise <= 1'b0;
      end
      else
      begin
         meta   <= next_meta;
         sync   <= next_sync;
         sync_d <= next_sync_d;
         o_rise <= next_rise;
      end
   end
endmodule
`default_nettype wire

// >>> tb/ftp_fan_model.sv
// Fan tach model: square wave on the tach line, half period in clocks.
// Assumes the bench sets i_half; zero stalls the fan with the line resting high.
`timescale 1ns/10ps
`default_nettype none
module ftp_fan_model
(
   input  wire logic        i_clk_sys, // System clock
   input  wire logic [15:0] i_half,    // Clocks per half pulse, 0 stops
   output logic             o_tach     // Tach line, pulled up when idle
);
   logic [15:0] cnt;
   initial o_tach = 1'b1;
   initial cnt = 16'h0000;
   // Toggle off the sampling edge; two pulses make one revolution
   always @(negedge i_clk_sys)
      if (i_half == 16'h0000)
      begin
         o_tach <= 1'b1;
         cnt    <= 16'h0000;
      end
      else if (cnt + 16'h0001 >= i_half)
      begin
         o_tach <= ~o_tach;
         cnt    <= 16'h0000;
      end
      else
         cnt <= cnt + 16'h0001;
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Bench for the tach period monitor: registers, frozen read, limits, regulation.
// Assumes PULSES=2 and the fan model on the tach pin.
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic        i_clk_sys, i_rst_n, i_regulate, i_wr, i_rd, i_tach;
   logic [7:0]  i_addr, i_wdata, o_rdata, rd_val;
   logic        o_too_slow, o_too_fast, o_in_band, o_adjust_up, o_adjust_dn, o_new_period;
   logic [15:0] half, p, h, e, m;
   int          mismatches = 0, tests_run = 0, cyc = 0, seed = 50044, i, j;
   int          offs[6] = '{10, 11, -10, -11, 50, -50};
   ftp_monitor #(.PULSES(2)) DUT (.i_clk_sys, .i_rst_n, .i_tach, .i_regulate, .i_addr,
      .i_wr, .i_wdata, .i_rd, .o_rdata, .o_too_slow, .o_too_fast, .o_in_band,
      .o_adjust_up, .o_adjust_dn, .o_new_period);
   ftp_fan_model FAN (.i_clk_sys(i_clk_sys), .i_half(half), .o_tach(i_tach));
   // Clock, 25 ns period
   initial
   begin
      i_clk_sys = 1'b0;
      forever #12.5 i_clk_sys = ~i_clk_sys;
   end
   task give_verdict;
      if (mismatches == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Hang guard
   always @(posedge i_clk_sys)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         mismatches++;
         give_verdict;
      end
   end
   task chk(input string n, input logic [15:0] x, g);
      tests_run++;
      if (g !== x)
      begin
         mismatches++;
         $display("Error %s exp %h got %h", n, x, g);
      end
   endtask
   function logic near(input logic [15:0] a, b);
      return (a - b + 16'h0001) <= 16'h0002;
   endfunction
   // d is target minus period
   function logic [2:0] reg_exp(input int d);
      return {d <= 10 && d >= -10, d < -10, d > 10};
   endfunction
   task wr(input logic [7:0] a, d);
      @(negedge i_clk_sys);
      i_addr = a;
      i_wdata = d;
      i_wr = 1'b1;
      @(negedge i_clk_sys);
      i_wr = 1'b0;
   endtask
   task rd(input logic [7:0] a);
      @(negedge i_clk_sys);
      i_addr = a;
      i_rd = 1'b1;
      @(negedge i_clk_sys);
      i_rd = 1'b0;
      @(posedge i_clk_sys) #1 rd_val = o_rdata;
   endtask
   task wr16(input logic [7:0] a, input logic [15:0] v);
      wr(a, v[7:0]);
      wr(a + 8'h01, v[15:8]);
   endtask
   task rd16(input logic [7:0] a);
      rd(a);
      p[7:0] = rd_val;
      rd(a + 8'h01);
      p[15:8] = rd_val;
   endtask
   // Wait for a measurement, then let the flags land
   task wnp;
      do @(posedge i_clk_sys) #1; while (o_new_period !== 1'b1);
      repeat (2) @(posedge i_clk_sys) #1;
   endtask
   initial
   begin
      {i_rst_n, i_regulate, i_wr, i_rd, i_addr, i_wdata, half} = '0;
      repeat (16) @(negedge i_clk_sys);
      i_rst_n = 1'b1;
      // Power-on values, read-only and unmapped places
      rd16(ftp_pkg::ADDR_PERIOD_LOW); chk("period", 16'h0000, p);
      rd16(ftp_pkg::ADDR_SLOW_LOW); chk("slow", 16'hffff, p);
      rd16(ftp_pkg::ADDR_FAST_LOW); chk("fast", 16'h0000, p);
      rd16(ftp_pkg::ADDR_TARGET_LOW); chk("target", 16'hffff, p);
      wr(ftp_pkg::ADDR_PERIOD_LOW, 8'h5a);
      rd(ftp_pkg::ADDR_PERIOD_LOW); chk("ro", 16'h0000, 16'(rd_val));
      wr(8'h20, 8'h33);
      rd(8'h20); chk("unmapped", 16'h0000, 16'(rd_val));
      // High byte stays frozen across a speed change
      half = 16'd100;
      wnp;
      wnp;
      chk("slow0", 16'h0000, 16'(o_too_slow));
      chk("fast0", 16'h0000, 16'(o_too_fast));
      rd(ftp_pkg::ADDR_PERIOD_LOW);
      chk("low", 16'h0001, 16'(near({8'h01, rd_val}, 16'd400)));
      half = 16'd200;
      wnp;
      wnp;
      rd(ftp_pkg::ADDR_PERIOD_HIGH); chk("frozen", 16'h0001, 16'(rd_val));
      rd16(ftp_pkg::ADDR_PERIOD_LOW); chk("new", 16'h0001, 16'(near(p, 16'd800)));
      // Random speeds against limits and target
      for (i = 0; i < 4; i++)
      begin
         h = 16'd70 + 16'($unsigned($random(seed)) % 60);
         e = h << 2;
         half = h;
         wnp;
         wnp;
         rd16(ftp_pkg::ADDR_PERIOD_LOW); chk("per", 16'h0001, 16'(near(p, e)));
         m = p;
         for (j = 0; j < 2; j++)
         begin
            wr16(ftp_pkg::ADDR_SLOW_LOW, j ? e + 16'd20 : e - 16'd20);
            wr16(ftp_pkg::ADDR_FAST_LOW, j ? e + 16'd20 : e - 16'd20);
            wnp;
            chk("too_slow", 16'(j == 0), 16'(o_too_slow));
            chk("too_fast", 16'(j == 1), 16'(o_too_fast));
         end
         // Deadband edges against the measured period, then far off
         @(negedge i_clk_sys);
         i_regulate = 1'b1;
         for (j = 0; j < 6; j++)
         begin
            wr16(ftp_pkg::ADDR_TARGET_LOW, m + 16'(offs[j]));
            rd16(ftp_pkg::ADDR_TARGET_LOW); chk("tgt", m + 16'(offs[j]), p);
            wnp;
            chk("reg", 16'(reg_exp(offs[j])), 16'({o_in_band, o_adjust_up, o_adjust_dn}));
         end
         @(negedge i_clk_sys);
         i_regulate = 1'b0;
         wnp;
         chk("idle", 16'h0000, 16'({o_adjust_up, o_adjust_dn}));
      end
      give_verdict;
   end
endmodule
`default_nettype wire
